// ==== bbit_decoder.sv ====
// bbit_decoder: decodes bit, branch and no-op instructions, computes branch
// outcome, target, length and cycle count, and counts out execution cycles.
// assumes: fetch logic holds opcode bytes and operand values stable while
// start is pulsed; done pulses in the final cycle of the instruction.
// Contract
// - carry-bit logic and moves: 2 bytes, 2 cycles
// - carry jumps: 2 bytes, 2/4 cycles
// - bit jumps: 3 bytes, 3/5; clear variant clears
// - accumulator zero jumps: 2 bytes, 2/4
// - compare direct, jump: 3 bytes, 4/6
// - compare immediate acc/reg: 3 bytes, 3/5
// - compare immediate indirect: 3 bytes, 4/6
// - decrement register, jump: 2 bytes, 2/4
// - decrement direct, jump: 3 bytes, 3/5
// - short jump: 2 bytes, 4 cycles
// - indexed indirect jump: 1 byte, 4 cycles
// - counts for prefetch on; slow timing adds
// - relative offset signed, from next byte
// - page target stays in 2 kB page
// - full target is 16 bits anywhere
// - direct below 0x80 RAM, else SPECIAL_FUNCTION_REGISTER
// - register operand within selected bank
// - indirect address from register 0 or 1
// - 0xA5 acts as one-cycle one-byte no-op
`timescale 1ns/1ps
`default_nettype none
module bbit_decoder (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        start,
	input  wire logic [7:0]  opByte0,
	input  wire logic [7:0]  opByte1,
	input  wire logic [7:0]  opByte2,
	input  wire logic [15:0] pc,
	input  wire logic        carryIn,
	input  wire logic        bitIn,
	input  wire logic [7:0]  accIn,
	input  wire logic [7:0]  operandIn,
	input  wire logic [15:0] dataPointer,
	input  wire logic [1:0]  bankSelect,
	input  wire logic        prefetch_unit_on,
	input  wire logic        flash_read_timing_select,
	output logic             busy,
	output logic             done,
	output logic             known,
	output logic             branchTaken,
	output logic [15:0]      branchTarget,
	output logic [1:0]       instrLength,
	output logic [3:0]       cycleCount,
	output logic             bitClear,
	output logic             directIsSfr,
	output logic [4:0]       regAddr,
	output logic             indirectSel
);
	// ==========================================================
	// state
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} bbit_state_t;

	typedef struct packed {
		bbit_state_t state;
		logic [3:0]  left;
		logic        taken;
		logic [15:0] target;
		logic [1:0]  len;
		logic [3:0]  cycles;
		logic        clr;
		logic        known;
		logic        special_function_register;
		logic [4:0]  reg_a;
		logic        ind;
	} bbit_regs_t;

	bbit_regs_t st_r;
	bbit_regs_t st_nxt;

	// ==========================================================
	// classification
	function automatic bbit_pkg::bbit_class_t classify(input logic [7:0] op);
		bbit_pkg::bbit_class_t c;
		c = bbit_pkg::CL_OTHER;
		case (op)
			bbit_pkg::OP_NOP, bbit_pkg::OP_ALIAS:                 c = bbit_pkg::CL_NOP;
			bbit_pkg::OP_AND_BIT, bbit_pkg::OP_AND_NBIT,
			bbit_pkg::OP_OR_BIT, bbit_pkg::OP_OR_NBIT,
			bbit_pkg::OP_MOV_CBIT, bbit_pkg::OP_MOV_BITC:         c = bbit_pkg::CL_BITC;
			bbit_pkg::OP_JCY_SET, bbit_pkg::OP_JCY_CLR:           c = bbit_pkg::CL_JCY;
			bbit_pkg::OP_JBIT_SET, bbit_pkg::OP_JBIT_CLR:         c = bbit_pkg::CL_JBIT;
			bbit_pkg::OP_JBCLR:                                   c = bbit_pkg::CL_JBITCLR;
			bbit_pkg::OP_JACC_Z, bbit_pkg::OP_JACC_NZ:            c = bbit_pkg::CL_JACC;
			bbit_pkg::OP_CJ_DIR:                                  c = bbit_pkg::CL_CJDIR;
			bbit_pkg::OP_CJ_IMM:                                  c = bbit_pkg::CL_CJIMM;
			bbit_pkg::OP_CJ_IND0, bbit_pkg::OP_CJ_IND1:           c = bbit_pkg::CL_CJIND;
			bbit_pkg::OP_DJ_DIR:                                  c = bbit_pkg::CL_DJDIR;
			bbit_pkg::OP_REL_JMP:                                 c = bbit_pkg::CL_RELJMP;
			bbit_pkg::OP_IJMP:                                    c = bbit_pkg::CL_IJMP;
			bbit_pkg::OP_FJMP:                                    c = bbit_pkg::CL_FJMP;
			bbit_pkg::OP_FCALL:                                   c = bbit_pkg::CL_FCALL;
			default: begin
				if (op[7:3] == bbit_pkg::OP_CJ_REG)
					c = bbit_pkg::CL_CJIMM;
				else if (op[7:3] == bbit_pkg::OP_DJ_REG)
					c = bbit_pkg::CL_DJREG;
				else if (op[4:0] == bbit_pkg::OP_PJMP_LO)
					c = bbit_pkg::CL_PJMP;
				else if (op[4:0] == bbit_pkg::OP_PCALL_LO)
					c = bbit_pkg::CL_PCALL;
			end
		endcase
		return c;
	endfunction : classify

	// ==========================================================
	// decode of the presented instruction
	bbit_pkg::bbit_class_t cls;
	logic        cond;
	logic [1:0]  len;
	logic [3:0]  cycShort;
	logic [3:0]  cycLong;
	logic        isBranch;
	logic        isCond;
	logic [1:0]  tgtMode;
	logic [7:0]  relByte;
	logic [15:0] nextPc;
	logic [15:0] tgt;
	logic [7:0]  decResult;
	logic [3:0]  cycFinal;

	always_comb begin
		cls      = classify(opByte0);
		cond     = 1'b0;
		len      = bbit_pkg::LEN_1;
		cycShort = bbit_pkg::CYC_1;
		cycLong  = bbit_pkg::CYC_1;
		isBranch = 1'b0;
		isCond   = 1'b0;
		tgtMode  = 2'h0;
		relByte  = opByte1;
		decResult = operandIn - 8'h01;
		case (cls)
			bbit_pkg::CL_NOP: begin
				len = bbit_pkg::LEN_1;
			end
			bbit_pkg::CL_BITC: begin
				len = bbit_pkg::LEN_2;
				cycShort = bbit_pkg::CYC_2;
				cycLong  = bbit_pkg::CYC_2;
			end
			bbit_pkg::CL_JCY: begin
				len = bbit_pkg::LEN_2;
				{cycShort, cycLong} = {bbit_pkg::CYC_2, bbit_pkg::CYC_4};
				isCond = 1'b1;
				cond = (opByte0 == bbit_pkg::OP_JCY_SET) ? carryIn : !carryIn;
			end
			bbit_pkg::CL_JBIT, bbit_pkg::CL_JBITCLR: begin
				len = bbit_pkg::LEN_3;
				{cycShort, cycLong} = {bbit_pkg::CYC_3, bbit_pkg::CYC_5};
				isCond = 1'b1;
				relByte = opByte2;
				cond = (opByte0 == bbit_pkg::OP_JBIT_CLR) ? !bitIn : bitIn;
			end
			bbit_pkg::CL_JACC: begin
				len = bbit_pkg::LEN_2;
				{cycShort, cycLong} = {bbit_pkg::CYC_2, bbit_pkg::CYC_4};
				isCond = 1'b1;
				cond = (opByte0 == bbit_pkg::OP_JACC_Z) ? (accIn == 8'h00) : (accIn != 8'h00);
			end
			bbit_pkg::CL_CJDIR: begin
				len = bbit_pkg::LEN_3;
				{cycShort, cycLong} = {bbit_pkg::CYC_4, bbit_pkg::CYC_6};
				isCond = 1'b1;
				relByte = opByte2;
				cond = (accIn != operandIn);
			end
			bbit_pkg::CL_CJIMM: begin
				len = bbit_pkg::LEN_3;
				{cycShort, cycLong} = {bbit_pkg::CYC_3, bbit_pkg::CYC_5};
				isCond = 1'b1;
				relByte = opByte2;
				// accumulator form reads A itself, register form the fetched bank value
				cond = (((opByte0 == bbit_pkg::OP_CJ_IMM) ? accIn : operandIn) != opByte1);
			end
			bbit_pkg::CL_CJIND: begin
				len = bbit_pkg::LEN_3;
				{cycShort, cycLong} = {bbit_pkg::CYC_4, bbit_pkg::CYC_6};
				isCond = 1'b1;
				relByte = opByte2;
				cond = (operandIn != opByte1);
			end
			bbit_pkg::CL_DJREG: begin
				len = bbit_pkg::LEN_2;
				{cycShort, cycLong} = {bbit_pkg::CYC_2, bbit_pkg::CYC_4};
				isCond = 1'b1;
				cond = (decResult != 8'h00);
			end
			bbit_pkg::CL_DJDIR: begin
				len = bbit_pkg::LEN_3;
				{cycShort, cycLong} = {bbit_pkg::CYC_3, bbit_pkg::CYC_5};
				isCond = 1'b1;
				relByte = opByte2;
				cond = (decResult != 8'h00);
			end
			bbit_pkg::CL_RELJMP: begin
				len = bbit_pkg::LEN_2;
				{cycShort, cycLong} = {bbit_pkg::CYC_4, bbit_pkg::CYC_4};
				isBranch = 1'b1;
			end
			bbit_pkg::CL_IJMP: begin
				len = bbit_pkg::LEN_1;
				{cycShort, cycLong} = {bbit_pkg::CYC_4, bbit_pkg::CYC_4};
				isBranch = 1'b1;
				tgtMode = 2'h3;
			end
			bbit_pkg::CL_PJMP, bbit_pkg::CL_PCALL: begin
				len = bbit_pkg::LEN_2;
				{cycShort, cycLong} = {bbit_pkg::CYC_4, bbit_pkg::CYC_4};
				isBranch = 1'b1;
				tgtMode = 2'h1;
			end
			bbit_pkg::CL_FJMP, bbit_pkg::CL_FCALL: begin
				len = bbit_pkg::LEN_3;
				{cycShort, cycLong} = {bbit_pkg::CYC_5, bbit_pkg::CYC_5};
				isBranch = 1'b1;
				tgtMode = 2'h2;
			end
			default: begin
				len = bbit_pkg::LEN_1;
			end
		endcase
		if (isCond)
			isBranch = cond;
		nextPc = pc + {14'h0000, len};
	end

	bbit_target u_target (
		.mode        (tgtMode),
		.nextPc      (nextPc),
		.opByte0     (opByte0),
		.opByte1     (opByte1),
		.opByte2     (opByte2),
		.rel         (relByte),
		.accIn       (accIn),
		.dataPointer (dataPointer),
		.target      (tgt)
	);

	// ==========================================================
	// final cycle count
	// slow flash and no prefetch only stretch taken branches; linear code streams
	always_comb begin
		cycFinal = isBranch ? cycLong : cycShort;
		if (isBranch && flash_read_timing_select)
			cycFinal = cycFinal + bbit_pkg::CYC_SLOW_EXTRA;
		if (isBranch && !prefetch_unit_on)
			cycFinal = cycFinal + bbit_pkg::CYC_NOPF_EXTRA;
	end

	// ==========================================================
	// sequencing
	always_comb begin
		st_nxt = st_r;
		case (st_r.state)
			ST_IDLE: begin
				if (start) begin
					st_nxt.taken  = isBranch;
					st_nxt.target = isBranch ? tgt : nextPc;
					st_nxt.len    = len;
					st_nxt.cycles = cycFinal;
					st_nxt.left   = cycFinal - 4'h1;
					st_nxt.clr    = (cls == bbit_pkg::CL_JBITCLR) && cond;
					st_nxt.known  = (cls != bbit_pkg::CL_OTHER);
					st_nxt.special_function_register    = (opByte1 >= bbit_pkg::DIRECT_SFR_BASE);
					st_nxt.reg_a  = {bankSelect, opByte0[2:0]};
					st_nxt.ind    = opByte0[0];
					if (cycFinal != bbit_pkg::CYC_1)
						st_nxt.state = ST_RUN;
				end
			end
			ST_RUN: begin
				st_nxt.left = st_r.left - 4'h1;
				if (st_r.left == 4'h1)
					st_nxt.state = ST_IDLE;
			end
			default: st_nxt.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// single-cycle ops finish in the start cycle itself
	assign busy         = (st_r.state == ST_RUN);
	assign done         = (st_r.state == ST_IDLE) ? (start && cycFinal == bbit_pkg::CYC_1)
	                                              : (st_r.left == 4'h1);
	assign known        = st_r.known;
	assign branchTaken  = st_r.taken;
	assign branchTarget = st_r.target;
	assign instrLength  = st_r.len;
	assign cycleCount   = st_r.cycles;
	assign bitClear     = st_r.clr;
	assign directIsSfr  = st_r.special_function_register;
	assign regAddr      = st_r.reg_a;
	assign indirectSel  = st_r.ind;
endmodule : bbit_decoder
`default_nettype wire

// ==== bbit_decoder_sva.sv ====
// bbit_decoder_sva: port-level timing and decode checks for the decoder.
// assumes: bound onto every bbit_decoder instance; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module bbit_decoder_sva (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        start,
	input wire logic [7:0]  opByte0,
	input wire logic [7:0]  opByte1,
	input wire logic [7:0]  opByte2,
	input wire logic [15:0] pc,
	input wire logic        carryIn,
	input wire logic [7:0]  accIn,
	input wire logic [15:0] dataPointer,
	input wire logic [1:0]  bankSelect,
	input wire logic        prefetch_unit_on,
	input wire logic        flash_read_timing_select,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        branchTaken,
	input wire logic [15:0] branchTarget,
	input wire logic [1:0]  instrLength,
	input wire logic [3:0]  cycleCount,
	input wire logic        directIsSfr,
	input wire logic [4:0]  regAddr
);
	// ==========================================================
	// helpers
	logic        take;
	logic        fast;
	logic [15:0] relExt;
	logic [15:0] pageNext;
	logic [15:0] pageTgt;
	logic [4:0]  regSel;
	logic [3:0]  busyCnt_r;
	assign take = start && !busy;
	assign fast = prefetch_unit_on && !flash_read_timing_select;
	assign relExt = {{8{opByte1[7]}}, opByte1};
	assign pageNext = pc + 16'h0002;
	assign pageTgt = {pageNext[15:11], opByte0[7:5], opByte1};
	assign regSel = {bankSelect, opByte0[2:0]};
	// busy cycles seen so far, ties done to the reported count
	always_ff @(posedge clk) begin
		if (srst || !busy) begin
			busyCnt_r <= 4'h0;
		end else begin
			busyCnt_r <= busyCnt_r + 4'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// ==========================================================
	// assertions
	a_nop_alias: assert property (take && (opByte0 == 8'h00 || opByte0 == 8'hA5) |-> done ##1
		(instrLength == 2'h1 && cycleCount == 4'h1)) else $error("no-op timing wrong");
	a_count_match: assert property (done && busy |-> busyCnt_r + 4'h2 == cycleCount)
		else $error("done not in last counted cycle");
	a_busy_hold: assert property (busy |=> $stable(branchTarget) && $stable(cycleCount))
		else $error("results changed while busy");
	a_carry_jump: assert property (take && fast && (opByte0 == 8'h40 || opByte0 == 8'h50) |=>
		cycleCount == (($past(carryIn) ^ $past(opByte0[4])) ? 4'h4 : 4'h2)) else $error("carry jump count");
	a_short_jump: assert property (take && fast && opByte0 == 8'h80 |=> branchTaken && cycleCount == 4'h4
		&& branchTarget == $past(pc) + 16'h0002 + $past(relExt)) else $error("short jump wrong");
	a_indirect_jump: assert property (take && opByte0 == 8'h73 |=> instrLength == 2'h1
		&& branchTarget == {8'h00, $past(accIn)} + $past(dataPointer)) else $error("indexed jump wrong");
	a_full_jump: assert property (take && (opByte0 == 8'h02 || opByte0 == 8'h12) |=> instrLength == 2'h3
		&& branchTarget == {$past(opByte1), $past(opByte2)}) else $error("full target wrong");
	a_page_jump: assert property (take && opByte0[3:0] == 4'h1 |=> instrLength == 2'h2
		&& branchTarget == $past(pageTgt)) else $error("page target wrong");
	a_sfr_flag: assert property (take |=> directIsSfr == ($past(opByte1) >= 8'h80))
		else $error("direct space flag wrong");
	a_bank_reg: assert property (take && opByte0[7:3] == 5'h1B |=> regAddr == $past(regSel))
		else $error("bank register address wrong");
	a_slow_extra: assert property (take && prefetch_unit_on && flash_read_timing_select && opByte0 == 8'h80
		|=> cycleCount == 4'h5) else $error("slow flash count wrong");
endmodule : bbit_decoder_sva

bind bbit_decoder bbit_decoder_sva sva_u (.clk(clk), .srst(srst), .start(start), .opByte0(opByte0),
	.opByte1(opByte1), .opByte2(opByte2), .pc(pc), .carryIn(carryIn), .accIn(accIn),
	.dataPointer(dataPointer), .bankSelect(bankSelect), .prefetch_unit_on(prefetch_unit_on),
	.flash_read_timing_select(flash_read_timing_select), .busy(busy), .done(done),
	.branchTaken(branchTaken), .branchTarget(branchTarget), .instrLength(instrLength),
	.cycleCount(cycleCount), .directIsSfr(directIsSfr), .regAddr(regAddr));
`default_nettype wire

// ==== bbit_pkg.sv ====
// bbit_pkg: opcodes, instruction lengths and cycle counts for the
// bit/branch decode-and-timing block.
// assumes: single 250 MHz core clock, opcode byte presented by fetch logic.
`default_nettype none
package bbit_pkg;
	// ==========================================================
	// opcode classes
	typedef enum logic [4:0] {
		CL_NOP     = 5'h00,
		CL_BITC    = 5'h01,
		CL_JCY     = 5'h02,
		CL_JBIT    = 5'h03,
		CL_JBITCLR = 5'h04,
		CL_JACC    = 5'h05,
		CL_CJDIR   = 5'h06,
		CL_CJIMM   = 5'h07,
		CL_CJIND   = 5'h08,
		CL_DJREG   = 5'h09,
		CL_DJDIR   = 5'h0A,
		CL_RELJMP  = 5'h0B,
		CL_IJMP    = 5'h0C,
		CL_PJMP    = 5'h0D,
		CL_PCALL   = 5'h0E,
		CL_FJMP    = 5'h0F,
		CL_FCALL   = 5'h10,
		CL_OTHER   = 5'h11
	} bbit_class_t;

	// ==========================================================
	// opcode values
	localparam logic [7:0] OP_NOP      = 8'h00;
	localparam logic [7:0] OP_ALIAS    = 8'hA5;
	localparam logic [7:0] OP_AND_BIT  = 8'h82;
	localparam logic [7:0] OP_AND_NBIT = 8'hB0;
	localparam logic [7:0] OP_OR_BIT   = 8'h72;
	localparam logic [7:0] OP_OR_NBIT  = 8'hA0;
	localparam logic [7:0] OP_MOV_CBIT = 8'hA2;
	localparam logic [7:0] OP_MOV_BITC = 8'h92;
	localparam logic [7:0] OP_JCY_SET  = 8'h40;
	localparam logic [7:0] OP_JCY_CLR  = 8'h50;
	localparam logic [7:0] OP_JBIT_SET = 8'h20;
	localparam logic [7:0] OP_JBIT_CLR = 8'h30;
	localparam logic [7:0] OP_JBCLR    = 8'h10;
	localparam logic [7:0] OP_JACC_Z   = 8'h60;
	localparam logic [7:0] OP_JACC_NZ  = 8'h70;
	localparam logic [7:0] OP_CJ_DIR   = 8'hB5;
	localparam logic [7:0] OP_CJ_IMM   = 8'hB4;
	localparam logic [7:0] OP_CJ_IND0  = 8'hB6;
	localparam logic [7:0] OP_CJ_IND1  = 8'hB7;
	localparam logic [4:0] OP_CJ_REG   = 5'h17;
	localparam logic [4:0] OP_DJ_REG   = 5'h1B;
	localparam logic [7:0] OP_DJ_DIR   = 8'hD5;
	localparam logic [7:0] OP_REL_JMP  = 8'h80;
	localparam logic [7:0] OP_IJMP     = 8'h73;
	localparam logic [4:0] OP_PJMP_LO  = 5'h01;
	localparam logic [4:0] OP_PCALL_LO = 5'h11;
	localparam logic [7:0] OP_FJMP     = 8'h02;
	localparam logic [7:0] OP_FCALL    = 8'h12;

	// ==========================================================
	// lengths and cycles
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic [3:0] CYC_1 = 4'h1;
	localparam logic [3:0] CYC_2 = 4'h2;
	localparam logic [3:0] CYC_3 = 4'h3;
	localparam logic [3:0] CYC_4 = 4'h4;
	localparam logic [3:0] CYC_5 = 4'h5;
	localparam logic [3:0] CYC_6 = 4'h6;
	// extra cycles per taken branch with slow flash timing
	localparam logic [3:0] CYC_SLOW_EXTRA = 4'h1;
	// stall when prefetch is off (assumed flash access)
	localparam logic [3:0] CYC_NOPF_EXTRA = 4'h2;

	// ==========================================================
	// address map
	localparam logic [7:0] DIRECT_SFR_BASE = 8'h80;
	localparam int         PAGE_BITS       = 11;
	localparam logic [2:0] BANK_REG_BITS   = 3'h3;
endpackage : bbit_pkg
`default_nettype wire

// ==== bbit_target.sv ====
// bbit_target: branch target arithmetic for the decoder.
// assumes: nextPc is the address of the byte after the instruction.
`timescale 1ns/1ps
`default_nettype none
module bbit_target (
	input  wire logic [1:0]  mode,
	input  wire logic [15:0] nextPc,
	input  wire logic [7:0]  opByte0,
	input  wire logic [7:0]  opByte1,
	input  wire logic [7:0]  opByte2,
	input  wire logic [7:0]  rel,
	input  wire logic [7:0]  accIn,
	input  wire logic [15:0] dataPointer,
	output logic      [15:0] target
);
	// mode 0 relative, 1 page, 2 full, 3 indexed indirect
	always_comb begin
		case (mode)
			2'h0:    target = nextPc + {{8{rel[7]}}, rel};
			2'h1:    target = {nextPc[15:11], opByte0[7:5], opByte1};
			2'h2:    target = {opByte1, opByte2};
			default: target = dataPointer + {8'h00, accIn};
		endcase
	end
endmodule : bbit_target
`default_nettype wire

// ==== tb.sv ====
// tb: self-checking bench for the bit/branch decoder.
// assumes: decoder contract of start/done/busy, 4 ns clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, srst, start, carryIn, bitIn, prefetch_unit_on, flash_read_timing_select;
	logic [7:0]  opByte0, opByte1, opByte2, accIn, operandIn;
	logic [15:0] pc, dataPointer, branchTarget;
	logic [1:0]  bankSelect, instrLength;
	logic        busy, done, known, branchTaken, bitClear, directIsSfr, indirectSel;
	logic [3:0]  cycleCount;
	logic [4:0]  regAddr;
	int          err_count, num_checks;

	bbit_decoder dut_u (.clk(clk), .srst(srst), .start(start), .opByte0(opByte0), .opByte1(opByte1),
		.opByte2(opByte2), .pc(pc), .carryIn(carryIn), .bitIn(bitIn), .accIn(accIn), .operandIn(operandIn),
		.dataPointer(dataPointer), .bankSelect(bankSelect), .prefetch_unit_on(prefetch_unit_on),
		.flash_read_timing_select(flash_read_timing_select), .busy(busy), .done(done), .known(known),
		.branchTaken(branchTaken), .branchTarget(branchTarget), .instrLength(instrLength),
		.cycleCount(cycleCount), .bitClear(bitClear), .directIsSfr(directIsSfr), .regAddr(regAddr),
		.indirectSel(indirectSel));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// one instruction, entered just after an edge; returns in the cycle after done, or two cycles after for one-cycle ops
	task automatic run(input logic [7:0] b0, b1, b2, input logic tk, input logic [1:0] len,
			input logic [3:0] cyc, input logic [15:0] tgt);
		logic d;
		int   n;
		opByte0 = b0;
		opByte1 = b1;
		opByte2 = b2;
		start = 1'b1;
		#1;
		d = (done === 1'b1);
		n = 1;
		@(posedge clk);
		#1;
		start = 1'b0;
		while (!d && n < 12) begin
			n++;
			#1;
			d = (done === 1'b1);
			@(posedge clk);
			#1;
		end
		// lets an edge pass with start low, so the next call never re-drives it at once
		if (n == 1) begin
			@(posedge clk);
			#1;
		end
		chk(16'(n), {12'h000, cyc}, "cycles to done");
		chk({12'h000, cycleCount}, {12'h000, cyc}, "cycle count");
		chk({15'h0000, branchTaken}, {15'h0000, tk}, "taken");
		chk({14'h0000, instrLength}, {14'h0000, len}, "length");
		chk(branchTarget, tgt, "target");
	endtask : run

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	// ==========================================================
	// scenarios
	task automatic t_carry();
		logic [7:0] ops [6] = '{8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92};
		pc = 16'h0040;
		foreach (ops[i]) begin
			run(ops[i], 8'h25, 8'h00, 1'b0, 2'h2, 4'h2, 16'h0042);
		end
		pc = 16'h0100;
		carryIn = 1'b1;
		run(8'h40, 8'hFE, 8'h00, 1'b1, 2'h2, 4'h4, 16'h0100);
		run(8'h50, 8'h7F, 8'h00, 1'b0, 2'h2, 4'h2, 16'h0102);
		carryIn = 1'b0;
		run(8'h40, 8'hFE, 8'h00, 1'b0, 2'h2, 4'h2, 16'h0102);
		run(8'h50, 8'h7F, 8'h00, 1'b1, 2'h2, 4'h4, 16'h0181);
		$display("carry tests done");
	endtask : t_carry

	task automatic t_bit_acc();
		pc = 16'h2000;
		bitIn = 1'b1;
		run(8'h20, 8'h33, 8'h80, 1'b1, 2'h3, 4'h5, 16'h1F83);
		run(8'h30, 8'h33, 8'h80, 1'b0, 2'h3, 4'h3, 16'h2003);
		run(8'h10, 8'h33, 8'h10, 1'b1, 2'h3, 4'h5, 16'h2013);
		chk({15'h0000, bitClear}, 16'h0001, "bit clear");
		bitIn = 1'b0;
		run(8'h10, 8'h33, 8'h10, 1'b0, 2'h3, 4'h3, 16'h2003);
		chk({15'h0000, bitClear}, 16'h0000, "bit clear");
		accIn = 8'h00;
		run(8'h60, 8'h05, 8'h00, 1'b1, 2'h2, 4'h4, 16'h2007);
		run(8'h70, 8'h05, 8'h00, 1'b0, 2'h2, 4'h2, 16'h2002);
		accIn = 8'h01;
		run(8'h70, 8'hFB, 8'h00, 1'b1, 2'h2, 4'h4, 16'h1FFD);
		$display("bit and accumulator tests done");
	endtask : t_bit_acc

	task automatic t_compare();
		pc = 16'h0400;
		accIn = 8'h55;
		operandIn = 8'h55;
		run(8'hB5, 8'h80, 8'h10, 1'b0, 2'h3, 4'h4, 16'h0403);
		chk({15'h0000, directIsSfr}, 16'h0001, "sfr flag");
		operandIn = 8'h54;
		run(8'hB5, 8'h7F, 8'h10, 1'b1, 2'h3, 4'h6, 16'h0413);
		chk({15'h0000, directIsSfr}, 16'h0000, "sfr flag");
		run(8'hB4, 8'h55, 8'hF0, 1'b0, 2'h3, 4'h3, 16'h0403);
		run(8'hB4, 8'h56, 8'hF0, 1'b1, 2'h3, 4'h5, 16'h03F3);
		bankSelect = 2'h2;
		run(8'hBD, 8'h54, 8'h02, 1'b0, 2'h3, 4'h3, 16'h0403);
		chk({11'h000, regAddr}, 16'h0015, "register address");
		run(8'hB7, 8'h00, 8'h04, 1'b1, 2'h3, 4'h6, 16'h0407);
		chk({15'h0000, indirectSel}, 16'h0001, "indirect select");
		run(8'hB6, 8'h54, 8'h04, 1'b0, 2'h3, 4'h4, 16'h0403);
		chk({15'h0000, indirectSel}, 16'h0000, "indirect select");
		pc = 16'h0500;
		operandIn = 8'h01;
		run(8'hD9, 8'h10, 8'h00, 1'b0, 2'h2, 4'h2, 16'h0502);
		operandIn = 8'h00;
		run(8'hD9, 8'h10, 8'h00, 1'b1, 2'h2, 4'h4, 16'h0512);
		operandIn = 8'h02;
		run(8'hD5, 8'h30, 8'hF0, 1'b1, 2'h3, 4'h5, 16'h04F3);
		operandIn = 8'h01;
		run(8'hD5, 8'h30, 8'hF0, 1'b0, 2'h3, 4'h3, 16'h0503);
		$display("compare and decrement tests done");
	endtask : t_compare

	task automatic t_uncond();
		pc = 16'h17FE;
		accIn = 8'hFF;
		dataPointer = 16'hFF01;
		run(8'h80, 8'h02, 8'h00, 1'b1, 2'h2, 4'h4, 16'h1802);
		run(8'h73, 8'h00, 8'h00, 1'b1, 2'h1, 4'h4, 16'h0000);
		run(8'hE1, 8'h34, 8'h00, 1'b1, 2'h2, 4'h4, 16'h1F34);
		run(8'h11, 8'h34, 8'h00, 1'b1, 2'h2, 4'h4, 16'h1834);
		run(8'h02, 8'hAB, 8'hCD, 1'b1, 2'h3, 4'h5, 16'hABCD);
		run(8'h12, 8'h00, 8'h10, 1'b1, 2'h3, 4'h5, 16'h0010);
		pc = 16'h0100;
		flash_read_timing_select = 1'b1;
		run(8'h80, 8'h10, 8'h00, 1'b1, 2'h2, 4'h5, 16'h0112);
		carryIn = 1'b1;
		run(8'h40, 8'h10, 8'h00, 1'b1, 2'h2, 4'h5, 16'h0112);
		carryIn = 1'b0;
		run(8'h40, 8'h10, 8'h00, 1'b0, 2'h2, 4'h2, 16'h0102);
		flash_read_timing_select = 1'b0;
		prefetch_unit_on = 1'b0;
		run(8'h80, 8'h10, 8'h00, 1'b1, 2'h2, 4'h6, 16'h0112);
		prefetch_unit_on = 1'b1;
		$display("jump and timing mode tests done");
	endtask : t_uncond

	task automatic t_alias();
		pc = 16'h0600;
		run(8'hA5, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1, 16'h0601);
		chk({15'h0000, known}, 16'h0001, "known");
		run(8'h00, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1, 16'h0601);
		run(8'h04, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1, 16'h0601);
		chk({15'h0000, known}, 16'h0000, "unlisted opcode");
		$display("no-op tests done");
	endtask : t_alias

	// ==========================================================
	// main sequence and watchdog
	initial begin
		{srst, start, carryIn, bitIn, flash_read_timing_select} = 5'h10;
		prefetch_unit_on = 1'b1;
		{opByte0, opByte1, opByte2, accIn, operandIn} = 40'h0;
		{pc, dataPointer, bankSelect} = 34'h0;
		repeat (4) @(posedge clk);
		#1;
		srst = 1'b0;
		chk({15'h0000, busy}, 16'h0000, "busy after reset");
		chk({12'h000, cycleCount}, 16'h0000, "count after reset");
		t_carry();
		t_bit_acc();
		t_compare();
		t_uncond();
		t_alias();
		final_report();
	end

	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		$display("watchdog expired");
		final_report();
	end
endmodule : tb
`default_nettype wire
